// ---- hw/lcm_messenger.sv ----
/*
  Link code messenger: sends and detects six-bit codes on the data link
  bit positions, with an APB register port.
  Assumes the framer strobes on i_core_clk for each link bit slot.
*/
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module lcm_messenger (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_dl_tx_req,
  output logic o_dl_tx_bit,
  input wire logic i_dl_rx_valid,
  input wire logic i_dl_rx_bit,
  output logic o_link_irq
);

  typedef struct packed {
    logic [4:0] ctl;
    logic [7:0] tx_word;
    logic [5:0] mask;
    logic [5:0] stat;
    logic [7:0] match_a;
    logic [7:0] match_b;
    logic rst_prev;
    logic [3:0] tx_idx;
    logic [5:0] tx_sh;
    logic tx_bit;
    lcm_pkg::lcm_rx_st_t rx_st;
    logic [3:0] rx_ones;
    logic [2:0] rx_cnt;
    logic [5:0] rx_sh;
    logic [5:0] cand;
    logic [2:0] run;
    logic [5:0] code;
    logic [4:0] clr_cnt;
    logic [31:0] prdata;
  } lcm_state_t;

  localparam lcm_state_t RST_VAL = '{
    ctl: lcm_pkg::LCM_CTL_RST_VAL, tx_word: 8'h00, mask: lcm_pkg::LCM_MASK_RST_VAL,
    stat: 6'h00, match_a: 8'h00, match_b: 8'h00, rst_prev: 1'b0,
    tx_idx: 4'h0, tx_sh: 6'h00, tx_bit: 1'b1, rx_st: lcm_pkg::LCM_RX_HUNT,
    rx_ones: 4'h0, rx_cnt: 3'h0, rx_sh: 6'h00, cand: 6'h00, run: 3'h0,
    code: lcm_pkg::LCM_CODE_RST, clr_cnt: 5'h00, prdata: 32'h0000_0000};

  lcm_state_t r;
  lcm_state_t n;
  logic [7:0] idx;
  logic hit;
  logic wr;
  logic rst_rise;
  logic rx_en;
  logic [5:0] set_ev;
  logic [5:0] clr_ev;
  logic [2:0] need;
  logic [2:0] run_n;

  //////////////////////////////////////////////////////////////////////
  // Address decode; unmapped indices answer with an error
  always_comb
  begin
    idx = i_paddr[9:2];
    case (idx)
      lcm_pkg::LCM_IDX_STATUS, lcm_pkg::LCM_IDX_MASK, lcm_pkg::LCM_IDX_CTL,
      lcm_pkg::LCM_IDX_RXW, lcm_pkg::LCM_IDX_TXW, lcm_pkg::LCM_IDX_MATCH_A,
      lcm_pkg::LCM_IDX_MATCH_B: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Zero-wait slave: read data was captured in the setup cycle
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit;
  assign o_prdata = r.prdata;
  assign o_dl_tx_bit = r.tx_bit;
  assign o_link_irq = |(r.stat & r.mask);

  //////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block
  always_comb
  begin
    n = r;
    set_ev = 6'h00;
    clr_ev = 6'h00;
    run_n = 3'h0;
    wr = i_psel & i_penable & i_pwrite & hit;
    rx_en = r.ctl[lcm_pkg::LCM_CTL_RXEN];
    rst_rise = r.ctl[lcm_pkg::LCM_CTL_RST] & ~r.rst_prev;
    n.rst_prev = r.ctl[lcm_pkg::LCM_CTL_RST];
    case (r.ctl[lcm_pkg::LCM_CTL_FLT_LO +: 2])
      2'b01: need = lcm_pkg::LCM_DEPTH_1;
      2'b10: need = lcm_pkg::LCM_DEPTH_2;
      2'b11: need = lcm_pkg::LCM_DEPTH_3;
      default: need = lcm_pkg::LCM_DEPTH_NONE;
    endcase

    // Register writes; status is write-one-to-clear
    if (wr)
    begin
      case (idx)
        // upper control bits are not stored
        lcm_pkg::LCM_IDX_CTL: n.ctl = i_pwdata[4:0];
        lcm_pkg::LCM_IDX_MASK: n.mask = i_pwdata[5:0];
        lcm_pkg::LCM_IDX_TXW: n.tx_word = i_pwdata[7:0];
        lcm_pkg::LCM_IDX_MATCH_A: n.match_a = i_pwdata[7:0];
        lcm_pkg::LCM_IDX_MATCH_B: n.match_b = i_pwdata[7:0];
        lcm_pkg::LCM_IDX_STATUS: clr_ev = i_pwdata[5:0];
        default: n.ctl = r.ctl;
      endcase
    end

    // Read data captured in setup so it stands through the access cycle
    if (i_psel & ~i_penable & ~i_pwrite)
    begin
      case (idx)
        lcm_pkg::LCM_IDX_STATUS: n.prdata = {26'h0, r.stat};
        lcm_pkg::LCM_IDX_MASK: n.prdata = {26'h0, r.mask};
        lcm_pkg::LCM_IDX_CTL: n.prdata = {27'h0, r.ctl};
        lcm_pkg::LCM_IDX_RXW: n.prdata = rx_en ? {26'h0, r.code} : 32'h0000_0000;
        lcm_pkg::LCM_IDX_TXW: n.prdata = {24'h0, r.tx_word};
        lcm_pkg::LCM_IDX_MATCH_A: n.prdata = {24'h0, r.match_a};
        lcm_pkg::LCM_IDX_MATCH_B: n.prdata = {24'h0, r.match_b};
        default: n.prdata = 32'h0000_0000;
      endcase
    end

    //////////////////////////////////////////////////////////////////////
    // insertion runs while the send bit is set, restarting at the lead zero
    if (!r.ctl[lcm_pkg::LCM_CTL_SEND])
    begin
      n.tx_idx = 4'h0;
      n.tx_bit = 1'b1;
    end
    else if (i_dl_tx_req)
    begin
      n.tx_idx = r.tx_idx + 4'h1;
      // zero, six code bits msb first, zero, eight ones
      if (r.tx_idx == 4'h0)
      begin
        n.tx_bit = 1'b0;
        // word taken into the shifter, buffer empty
        n.tx_sh = r.tx_word[5:0];
        set_ev[lcm_pkg::LCM_EV_TXEMPTY] = 1'b1;
      end
      else if (r.tx_idx < lcm_pkg::LCM_TX_STOP)
      begin
        n.tx_bit = r.tx_sh[5];
        n.tx_sh = {r.tx_sh[4:0], 1'b0};
      end
      else
      begin
        n.tx_bit = (r.tx_idx != lcm_pkg::LCM_TX_STOP);
      end
    end

    //////////////////////////////////////////////////////////////////////
    // Receiver; a reset edge wins over any bit arriving in the same cycle
    if (rst_rise)
    begin
      // message bits back to all ones
      n.code = lcm_pkg::LCM_CODE_RST;
      n.rx_st = lcm_pkg::LCM_RX_HUNT;
      n.rx_ones = 4'h0;
      n.rx_cnt = 3'h0;
      n.run = 3'h0;
      n.cand = 6'h00;
      n.clr_cnt = 5'h00;
    end
    else if (!rx_en)
    begin
      n.rx_st = lcm_pkg::LCM_RX_HUNT;
      n.rx_ones = 4'h0;
    end
    else if (i_dl_rx_valid)
    begin
      n.rx_ones = i_dl_rx_bit ? ((r.rx_ones == lcm_pkg::LCM_ONES_ABORT) ?
        r.rx_ones : r.rx_ones + 4'h1) : 4'h0;
      // count bits since the last abort, event once at thirty
      if (r.clr_cnt != lcm_pkg::LCM_CLEAR_BITS)
      begin
        n.clr_cnt = r.clr_cnt + 5'h01;
        if (r.clr_cnt == lcm_pkg::LCM_CLEAR_BITS - 5'h01)
          set_ev[lcm_pkg::LCM_EV_CLEAR] = 1'b1;
      end
      case (r.rx_st)
        lcm_pkg::LCM_RX_START:
        begin
          if (!i_dl_rx_bit)
          begin
            n.rx_st = lcm_pkg::LCM_RX_DATA;
            n.rx_cnt = 3'h0;
          end
        end
        lcm_pkg::LCM_RX_DATA:
        begin
          n.rx_sh = {r.rx_sh[4:0], i_dl_rx_bit};
          n.rx_cnt = r.rx_cnt + 3'h1;
          if (r.rx_cnt == lcm_pkg::LCM_DATA_LAST)
            n.rx_st = lcm_pkg::LCM_RX_STOP;
        end
        lcm_pkg::LCM_RX_STOP:
        begin
          n.rx_st = lcm_pkg::LCM_RX_HUNT;
          if (!i_dl_rx_bit)
          begin
            run_n = (r.rx_sh == r.cand && r.run != 3'h0) ?
              ((r.run == lcm_pkg::LCM_DEPTH_3) ? r.run : r.run + 3'h1) : 3'h1;
            n.run = run_n;
            n.cand = r.rx_sh;
            // change to a newly validated code
            if (run_n >= need && r.rx_sh != r.code)
            begin
              n.code = r.rx_sh;
              set_ev[lcm_pkg::LCM_EV_CHANGE] = 1'b1;
              set_ev[lcm_pkg::LCM_EV_RXFULL] = 1'b1;
              // new word compared with both match words
              if ({2'b00, r.rx_sh} == r.match_a || {2'b00, r.rx_sh} == r.match_b)
                set_ev[lcm_pkg::LCM_EV_MATCH] = 1'b1;
            end
          end
        end
        default: n.rx_st = lcm_pkg::LCM_RX_HUNT;
      endcase
      // eighth consecutive one is an abort flag
      if (i_dl_rx_bit && r.rx_ones == lcm_pkg::LCM_ONES_ABORT - 4'h1)
      begin
        set_ev[lcm_pkg::LCM_EV_ABORT] = 1'b1;
        n.clr_cnt = 5'h00;
        n.rx_st = lcm_pkg::LCM_RX_START;
      end
    end

    // Set wins over a clear in the same cycle
    n.stat = (r.stat & ~clr_ev) | set_ev;
  end

  //////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      r <= RST_VAL;
    else
      r <= n;
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  property p_tx_zero;
    r.ctl[0] && i_dl_tx_req && (r.tx_idx == 4'h0 || r.tx_idx == 4'h7) |=> !o_dl_tx_bit;
  endproperty
  a_tx_zero: assert property (p_tx_zero) else $error("delimiter not zero");
  property p_tx_flag;
    r.ctl[0] && i_dl_tx_req && r.tx_idx >= 4'h8 |=> o_dl_tx_bit;
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("flag bit not one");
  property p_tx_off;
    !r.ctl[0] |=> r.tx_idx == 4'h0 && o_dl_tx_bit;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("sending while off");

  property p_rx_reset;
    r.ctl[3] && !r.rst_prev |=> r.code == 6'h3f && r.run == 3'h0;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("reset edge ignored");
  property p_rx_off;
    !r.ctl[4] && !(r.ctl[3] && !r.rst_prev) |=> $stable(r.code);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("code moved while off");
  property p_change;
    r.ctl[4] && !$stable(r.code) && r.code != 6'h3f |-> r.stat[0];
  endproperty
  a_change: assert property (p_change) else $error("change event missing");
  property p_abort;
    r.ctl[4] && i_dl_rx_valid && i_dl_rx_bit && r.rx_ones == 4'h7 && !rst_rise
      |=> r.stat[4] && r.clr_cnt == 5'h00;
  endproperty
  a_abort: assert property (p_abort) else $error("abort event missing");
  property p_clear;
    r.ctl[4] && i_dl_rx_valid && r.clr_cnt == 5'd29 && !rst_rise |=> r.stat[5];
  endproperty
  a_clear: assert property (p_clear) else $error("clear event missing");
  property p_empty;
    r.ctl[0] && i_dl_tx_req && r.tx_idx == 4'h0
      |=> r.stat[2] && {2'b00, r.tx_sh} == ($past(r.tx_word) & 8'h3f);
  endproperty
  a_empty: assert property (p_empty) else $error("empty event missing");
  property p_irq;
    r.stat[0] && r.mask[0] |-> o_link_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked event not raised");

  c_send: cover property (r.ctl[0] && i_dl_tx_req && r.tx_idx == lcm_pkg::LCM_TX_LAST);
  c_code: cover property (set_ev[0] && r.rx_sh == lcm_pkg::LCM_QL_STRATUM1);
  c_match: cover property (set_ev[1]);
  c_clear_race: cover property (set_ev[4] && clr_ev[4]);

endmodule // lcm_messenger
`default_nettype wire

// ---- pkg/lcm_pkg.sv ----
/*
  Constants and types for the link code messenger.
  Assumes APB byte addressing with one 32-bit word per register index.
*/
`default_nettype none
package lcm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] LCM_IDX_STATUS = 8'h24;
  localparam logic [7:0] LCM_IDX_MASK = 8'h25;
  localparam logic [7:0] LCM_IDX_CTL = 8'h37;
  localparam logic [7:0] LCM_IDX_RXW = 8'hc0;
  localparam logic [7:0] LCM_IDX_TXW = 8'hc1;
  localparam logic [7:0] LCM_IDX_MATCH_A = 8'hc2;
  localparam logic [7:0] LCM_IDX_MATCH_B = 8'hc3;
  // Control field positions
  localparam int LCM_CTL_SEND = 0;
  localparam int LCM_CTL_FLT_LO = 1;
  localparam int LCM_CTL_RST = 3;
  localparam int LCM_CTL_RXEN = 4;
  // Event bit positions
  localparam int LCM_EV_CHANGE = 0;
  localparam int LCM_EV_MATCH = 1;
  localparam int LCM_EV_TXEMPTY = 2;
  localparam int LCM_EV_RXFULL = 3;
  localparam int LCM_EV_ABORT = 4;
  localparam int LCM_EV_CLEAR = 5;
  // Reset and idle values
  localparam logic [5:0] LCM_CODE_RST = 6'h3f;
  localparam logic [4:0] LCM_CTL_RST_VAL = 5'h00;
  localparam logic [5:0] LCM_MASK_RST_VAL = 6'h00;
  // Frame shape: zero, six code bits, zero, eight ones
  localparam logic [3:0] LCM_TX_LAST = 4'hf;
  localparam logic [3:0] LCM_TX_STOP = 4'h7;
  localparam logic [3:0] LCM_ONES_ABORT = 4'h8;
  localparam logic [2:0] LCM_DATA_LAST = 3'h5;
  localparam logic [4:0] LCM_CLEAR_BITS = 5'd30;
  // Consecutive-match depth per filter setting
  localparam logic [2:0] LCM_DEPTH_NONE = 3'd1;
  localparam logic [2:0] LCM_DEPTH_1 = 3'd3;
  localparam logic [2:0] LCM_DEPTH_2 = 3'd5;
  localparam logic [2:0] LCM_DEPTH_3 = 3'd7;
  // Code points of the quality levels named at both ends
  localparam logic [5:0] LCM_QL_STRATUM1 = 6'b000010;
  localparam logic [5:0] LCM_QL_DONT_USE = 6'b011000;
  localparam logic [5:0] LCM_QL_NET_RSVD = 6'b100000;

  typedef enum logic [1:0] {LCM_RX_HUNT, LCM_RX_START, LCM_RX_DATA, LCM_RX_STOP} lcm_rx_st_t;
endpackage
`default_nettype wire

// ---- tb/lcm_far_end.sv ----
/*
  Far-end link model: slot strobes, a receive bit source, a transmit code monitor.
  Assumes it shares i_clk with the messenger.
*/
`timescale 1ns/100ps
`default_nettype none
module lcm_far_end (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_tx_bit,
  output logic o_tx_req,
  output logic o_rx_valid,
  output logic o_rx_bit,
  output logic [5:0] o_far_code,
  output logic o_far_valid,
  output logic [15:0] o_hist
);
  logic [1:0] slot_cnt;
  logic req_d;
  logic [3:0] same_cnt;
  logic [3:0] nc;
  logic [15:0] nh;
  // Quiet line at time zero
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_bit = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////
  // Slot strobe every fourth cycle; the bit is read one cycle later
  always @(posedge i_clk)
  begin
    nh = {o_hist[14:0], i_tx_bit};
    nc = (nh[14:9] == o_far_code) ? same_cnt + {3'd0, same_cnt != 4'd15} : 4'd1;
    slot_cnt <= i_srst ? 2'd0 : slot_cnt + 2'd1;
    o_tx_req <= !i_srst && (slot_cnt == 2'd3);
    req_d <= o_tx_req;
    if (i_srst)
    begin
      o_hist <= 16'hffff;
      same_cnt <= 4'd0;
      o_far_code <= 6'h3f;
      o_far_valid <= 1'b0;
    end
    else if (req_d)
    begin
      o_hist <= nh;
      if (!nh[15] && !nh[8] && nh[7:0] == 8'hff)
      begin
        same_cnt <= nc;
        o_far_code <= nh[14:9];
        o_far_valid <= (nc >= 4'd7);
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // One bit per two cycles; a released line shows the inverse, never a stale bit
  task automatic send_bit(input logic b);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_bit <= b;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_bit <= ~b;
  endtask
  // flag, zero, code msb first, zero
  task automatic send_frame(input logic [5:0] code);
    int i;
    for (i = 0; i < 8; i++)
      send_bit(1'b1);
    send_bit(1'b0);
    for (i = 5; i >= 0; i--)
      send_bit(code[i]);
    send_bit(1'b0);
  endtask
endmodule // lcm_far_end
`default_nettype wire

// ---- tb/lcm_messenger_test.sv ----
/*
  Self-checking bench for the link code messenger.
  Assumes lcm_far_end stands on the link side; registers are reached over APB.
*/
`timescale 1ns/100ps
`default_nettype none
module lcm_messenger_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tx_req;
  logic tx_bit;
  logic rx_valid;
  logic rx_bit;
  logic irq;
  logic [5:0] far_code;
  logic far_valid;
  logic [15:0] far_hist;
  logic [31:0] rd;
  logic err;
  logic [31:0] seed = 32'h0e2b_5ab8;
  logic [5:0] code;
  logic [4:0] ctl;
  logic [5:0] ql [3];
  int n_mismatch = 0;
  int cmp_count = 0;
  int k;
  int f;
  // Free-running core clock
  always #5 clk = ~clk;
  lcm_messenger DUT (.i_core_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_dl_tx_req(tx_req), .o_dl_tx_bit(tx_bit),
    .i_dl_rx_valid(rx_valid), .i_dl_rx_bit(rx_bit), .o_link_irq(irq));
  lcm_far_end far (.i_clk(clk), .i_srst(srst), .i_tx_bit(tx_bit), .o_tx_req(tx_req),
    .o_rx_valid(rx_valid), .o_rx_bit(rx_bit), .o_far_code(far_code),
    .o_far_valid(far_valid), .o_hist(far_hist));
  //////////////////////////////////////////////////////////////////////
  // Stimulus source
  function automatic logic [31:0] xs_next(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Status after one accepted code: change, full, abort, and match on a hit
  function automatic logic [31:0] exp_status(input logic hit);
    return {26'd0, 4'b0110, hit, 1'b1};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic check_irq(input logic e);
    @(posedge clk);
    check({31'd0, irq}, {31'd0, e});
  endtask
  // Bounded wait for the far end to trust a code
  task automatic wait_far(input logic [5:0] c);
    int n;
    n = 0;
    while (!(far_valid === 1'b1 && far_code === c) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    check({25'd0, far_valid, far_code}, {25'd0, 1'b1, c});
    if (n >= 3000)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    ql = '{lcm_pkg::LCM_QL_STRATUM1, lcm_pkg::LCM_QL_DONT_USE, lcm_pkg::LCM_QL_NET_RSVD};
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    apb(lcm_pkg::LCM_IDX_CTL, 1'b0, 32'h0000_0000);
    check(rd, {27'd0, lcm_pkg::LCM_CTL_RST_VAL});
    apb(lcm_pkg::LCM_IDX_RXW, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(lcm_pkg::LCM_IDX_MASK, 1'b0, 32'h0000_0000);
    check(rd, {26'd0, lcm_pkg::LCM_MASK_RST_VAL});
    apb(8'h10, 1'b0, 32'h0000_0000);
    check({err, rd[30:0]}, 32'h8000_0000);
    check({30'd0, irq, tx_bit}, 32'h0000_0001);
    $display("reset test done");
    for (k = 0; k < 3; k++)
    begin
      apb(lcm_pkg::LCM_IDX_TXW, 1'b1, {26'd0, ql[k]});
      apb(lcm_pkg::LCM_IDX_CTL, 1'b1, 32'h0000_0001);
      wait_far(ql[k]);
    end
    apb(lcm_pkg::LCM_IDX_STATUS, 1'b1, 32'h0000_003f);
    repeat (70) @(posedge clk);
    apb(lcm_pkg::LCM_IDX_STATUS, 1'b0, 32'h0000_0000);
    check(rd & 32'h0000_0004, 32'h0000_0004);
    apb(lcm_pkg::LCM_IDX_CTL, 1'b1, 32'h0000_0000);
    repeat (80) @(posedge clk);
    check({16'd0, far_hist}, 32'h0000_ffff);
    $display("transmit test done");
    for (f = 0; f < 4; f++)
    begin
      seed = xs_next(seed);
      code = (seed[5:0] == 6'h3f) ? 6'h15 : seed[5:0];
      ctl = {1'b1, 1'b0, f[1:0], 1'b0};
      // filter, enable, then rising reset edge
      apb(lcm_pkg::LCM_IDX_CTL, 1'b1, {27'd0, ctl});
      apb(lcm_pkg::LCM_IDX_CTL, 1'b1, {27'd0, ctl | 5'h08});
      apb(lcm_pkg::LCM_IDX_MATCH_A, 1'b1, {26'd0, (f == 0) ? code : ~code});
      apb(lcm_pkg::LCM_IDX_MATCH_B, 1'b1, {26'd0, (f == 1) ? code : ~code});
      apb(lcm_pkg::LCM_IDX_STATUS, 1'b1, 32'h0000_003f);
      apb(lcm_pkg::LCM_IDX_RXW, 1'b0, 32'h0000_0000);
      check(rd, 32'h0000_003f);
      for (k = 1; k < 2 * f + 1; k++)
        far.send_frame(code);
      apb(lcm_pkg::LCM_IDX_RXW, 1'b0, 32'h0000_0000);
      check(rd, 32'h0000_003f);
      far.send_frame(code);
      repeat (2) @(posedge clk);
      apb(lcm_pkg::LCM_IDX_STATUS, 1'b0, 32'h0000_0000);
      check(rd, exp_status(f < 2));
      apb(lcm_pkg::LCM_IDX_RXW, 1'b0, 32'h0000_0000);
      check(rd, {26'd0, code});
      apb(lcm_pkg::LCM_IDX_CTL, 1'b1, {27'd0, ctl | 5'h08});
      apb(lcm_pkg::LCM_IDX_RXW, 1'b0, 32'h0000_0000);
      check(rd, {26'd0, code});
      apb(lcm_pkg::LCM_IDX_MASK, 1'b1, 32'h0000_0000);
      check_irq(1'b0);
      apb(lcm_pkg::LCM_IDX_MASK, 1'b1, 32'h0000_0001);
      check_irq(1'b1);
      apb(lcm_pkg::LCM_IDX_STATUS, 1'b1, 32'h0000_0001);
      check_irq(1'b0);
      $display("receive test, filter %0d, done", f);
    end
    // fresh receiver, then count to the boundary
    apb(lcm_pkg::LCM_IDX_CTL, 1'b1, {27'd0, ctl});
    apb(lcm_pkg::LCM_IDX_CTL, 1'b1, {27'd0, ctl | 5'h08});
    apb(lcm_pkg::LCM_IDX_STATUS, 1'b1, 32'h0000_003f);
    for (k = 0; k < 29; k++)
      far.send_bit(1'b0);
    repeat (2) @(posedge clk);
    apb(lcm_pkg::LCM_IDX_STATUS, 1'b0, 32'h0000_0000);
    check(rd & 32'h0000_0030, 32'h0000_0000);
    far.send_bit(1'b0);
    repeat (2) @(posedge clk);
    apb(lcm_pkg::LCM_IDX_STATUS, 1'b0, 32'h0000_0000);
    check(rd & 32'h0000_0030, 32'h0000_0020);
    $display("clear test done");
    wrap_up();
  end
endmodule // lcm_messenger_test
`default_nettype wire
